// ---- bench/dcc_ana_model.sv ----
// Purpose: analog side model: pin voltages, reference and two comparators
// Assumes: voltages are unsigned codes, larger code means higher level
// Notes: results settle a fixed time after any level or routing change
`timescale 1ns/1ns
module dcc_ana_model
  import dcc_pkg::*;
#(
  parameter int RESP_NS = 5
) (
  input wire dcc_ana_t ana_ctrl,
  input wire logic [3:0][7:0] pin_v,
  input wire logic [7:0] vref_v,
  output logic [1:0] cmp_raw
);
  logic [7:0] p1, m1, p2, m2;
  logic [1:0] nxt;
  always_comb begin
    p1 = pin_v[0];
    m1 = pin_v[3];
    p2 = pin_v[1];
    m2 = (ana_ctrl.mode inside {MODE_COMMON, MODE_COMMON_OUT}) ? pin_v[3] : pin_v[2];
    if (ana_ctrl.vref_sel) begin
      p1 = vref_v;
      p2 = vref_v;
      m1 = ana_ctrl.input_switch ? pin_v[0] : pin_v[3];
      m2 = ana_ctrl.input_switch ? pin_v[1] : pin_v[2];
    end
  end
  // high when plus above minus, low when off
  always_comb begin
    nxt[0] = ana_ctrl.cmp_power[0] && (p1 > m1);
    nxt[1] = ana_ctrl.cmp_power[1] && (p2 > m2);
  end
  // result valid only after response delay
  initial begin
    cmp_raw = 2'b00;
    forever begin
      @(nxt);
      cmp_raw <= #RESP_NS nxt;
    end
  end
endmodule : dcc_ana_model

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for the dual comparator control block
// Assumes: one AHB-Lite master, analog side from the behavioural model
// Notes: waits on synchronised results allow the input filter delay
`timescale 1ns/1ns
module testbench;
  import dcc_pkg::*;
  localparam logic [7:0][5:0] MASKS = {6'h00, 6'h0f, 6'h09, 6'h0b, 6'h0b, 6'h0f, 6'h09, 6'h0f};
  localparam logic [7:0][1:0] POWER = {2'h0, 2'h3, 2'h1, 2'h3, 2'h3, 2'h3, 2'h1, 2'h0};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = WORD_ZERO;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = WORD_ZERO;
  logic sleep_active = 1'b0;
  logic [PA_W-1:0] port_a_in = 6'h3f;
  logic [PE_W-1:0] port_e_in = 3'h5;
  logic [3:0][7:0] pin_v = {4{8'h80}};
  logic [7:0] vref_v = 8'h40;
  logic hreadyout, hresp, pe1, pe1_oe, pe2, pe2_oe, irq, irq_priority, wake;
  logic [31:0] hrdata;
  logic [1:0] cmp_raw;
  logic [PA_W-1:0] port_a_oe, port_a_digital_en;
  dcc_ana_t ana_ctrl;
  int err_total = 0;
  int cmp_count = 0;

  dcc_top u_dcc_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_raw(cmp_raw),
    .port_a_in(port_a_in), .port_e_in(port_e_in), .sleep_active(sleep_active),
    .ana_ctrl(ana_ctrl), .port_a_oe(port_a_oe), .port_a_digital_en(port_a_digital_en),
    .port_e_pin_one(pe1), .port_e_pin_one_oe(pe1_oe), .port_e_pin_two(pe2),
    .port_e_pin_two_oe(pe2_oe), .irq(irq), .irq_priority(irq_priority), .wake(wake)
  );
  dcc_ana_model u_dcc_ana_model (
    .ana_ctrl(ana_ctrl), .pin_v(pin_v), .vref_v(vref_v), .cmp_raw(cmp_raw)
  );

  initial begin
    forever #25 hclk = ~hclk;
  end

  task automatic stop_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_total++;
      stop_test();
    end
  endtask : edge_ready

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, WORD_ZERO, d);
    chk(d, exp);
  endtask : rchk

  // input filter plus analog response
  task automatic settle();
    repeat (8) @(posedge hclk);
  endtask : settle

  task automatic wait_sig(input logic sel);
    int n;
    n = 0;
    while ((sel ? wake : irq) !== 1'b1 && n < 40) begin
      @(posedge hclk);
      n++;
    end
    chk(sel ? wake : irq, 1'b1);
    if (n >= 40) begin
      stop_test();
    end
  endtask : wait_sig

  task automatic t_reset();
    chk(ana_ctrl, 7'h00);
    rchk(OFF_CTRL, WORD_ZERO);
    rchk(OFF_DIR_A, 32'h3f);
    rchk(OFF_DIR_E, 32'h7);
    rchk(OFF_IRQ, WORD_ZERO);
    rchk(32'h0000_0040, WORD_ZERO);
    settle();
    rchk(OFF_PORT, 32'h530);
  endtask : t_reset

  // interrupt stays disabled while modes change
  task automatic t_modes();
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      wr(OFF_CTRL, {28'h0, 1'b1, m});
      rchk(OFF_CTRL, {28'h0, 1'b1, m});
      #1;
      chk(ana_ctrl.cmp_power, POWER[m]);
      chk(ana_ctrl.vref_sel, m == MODE_MUX_VREF);
      chk(ana_ctrl.input_switch, m == MODE_MUX_VREF);
      chk(port_a_digital_en, {26'h0, ~MASKS[m]});
      settle();
      rchk(OFF_PORT, {21'h0, 3'h5, 2'h0, 6'h3f & ~MASKS[m]});
    end
    wr(OFF_DIR_A, 32'h15);
    @(posedge hclk);
    #1;
    chk(port_a_oe, 6'h2a);
  endtask : t_modes

  task automatic t_results();
    @(posedge hclk);
    pin_v <= {8'h80, 8'h80, 8'h70, 8'h90};
    wr(OFF_CTRL, 32'hc2);
    settle();
    rchk(OFF_CTRL, 32'h42);
    wr(OFF_CTRL, 32'h32);
    settle();
    rchk(OFF_CTRL, 32'hb2);
    vref_v <= 8'h85;
    wr(OFF_CTRL, 32'h0e);
    settle();
    rchk(OFF_CTRL, 32'h8e);
    wr(OFF_CTRL, 32'h06);
    settle();
    chk(ana_ctrl.input_switch, 1'b0);
    rchk(OFF_CTRL, 32'hc6);
  endtask : t_results

  task automatic t_pins();
    wr(OFF_DIR_E, 32'h3);
    wr(OFF_CTRL, 32'h14);
    settle();
    chk({pe2_oe, pe1_oe}, 2'b10);
    chk({pe2, pe1}, 2'b00);
    pin_v <= {8'h80, 8'h80, 8'h90, 8'h70};
    #10;
    chk({pe2, pe1}, 2'b11);
    @(posedge hclk);
    wr(OFF_DIR_E, 32'h4);
    @(posedge hclk);
    #1;
    chk({pe2_oe, pe1_oe}, 2'b01);
    @(posedge hclk);
    wr(OFF_CTRL, 32'h02);
    // pin mode reaches the enables through the routing register
    repeat (2) @(posedge hclk);
    #1;
    chk({pe2_oe, pe1_oe}, 2'b00);
  endtask : t_pins

  task automatic t_irq();
    settle();
    rchk(OFF_CTRL, 32'h82);
    wr(OFF_IRQ, WORD_ZERO);
    rchk(OFF_IRQ, WORD_ZERO);
    for (int k = 0; k < 8; k++) begin
      wr(OFF_CORE, {30'h0, k[2:1]});
      wr(OFF_IRQ, {30'h0, k[0], 1'b1});
      @(posedge hclk);
      #1;
      chk(irq, k == 7);
      @(posedge hclk);
      rchk(OFF_IRQ, {30'h0, k[0], 1'b1});
    end
    wr(OFF_IRQ, 32'h2);
    rchk(OFF_IRQ, 32'h2);
    pin_v <= {8'h80, 8'h80, 8'h90, 8'h90};
    wait_sig(1'b0);
    wr(OFF_IRQ, 32'h2);
    settle();
    rchk(OFF_IRQ, 32'h3);
    rchk(OFF_CTRL, 32'hc2);
    wr(OFF_IRQ, 32'h2);
    settle();
    rchk(OFF_IRQ, 32'h2);
    sleep_active <= 1'b1;
    pin_v <= {8'h80, 8'h80, 8'h70, 8'h90};
    wait_sig(1'b1);
    sleep_active <= 1'b0;
    rchk(OFF_CTRL, 32'h42);
  endtask : t_irq

  task automatic t_rerst();
    wr(OFF_IRQ, 32'h6);
    repeat (2) @(posedge hclk);
    chk(irq_priority, 1'b1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({hresp, hreadyout, irq_priority, wake}, 4'b0100);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(OFF_CTRL, WORD_ZERO);
    rchk(OFF_IRQ, WORD_ZERO);
    rchk(OFF_DIR_A, 32'h3f);
  endtask : t_rerst

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_modes();
    t_results();
    t_pins();
    t_irq();
    t_rerst();
    stop_test();
  end
endmodule : testbench

// ---- rtl/dcc_pkg.sv ----
// Purpose: shared constants and types for the dual comparator control block
// Assumes: AHB-Lite slave at base zero, 32-bit data, one word per register
// Notes: analog comparison arrives as one digital result per comparator
package dcc_pkg;

  // register byte offsets
  localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFF_IRQ = 32'h0000_0004;
  localparam logic [31:0] OFF_CORE = 32'h0000_0008;
  localparam logic [31:0] OFF_DIR_A = 32'h0000_000c;
  localparam logic [31:0] OFF_DIR_E = 32'h0000_0010;
  localparam logic [31:0] OFF_PORT = 32'h0000_0014;

  // field positions outside the control register
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam int IRQ_PRIO_BIT = 2;
  localparam int CORE_PERI_BIT = 0;
  localparam int CORE_GLOB_BIT = 1;
  localparam int PORT_A_LSB = 0;
  localparam int PORT_E_LSB = 8;
  localparam int PIN_E_ONE = 1;
  localparam int PIN_E_TWO = 2;

  localparam int PA_W = 6;
  localparam int PE_W = 3;
  localparam int SYNC_W = 2 + PA_W + PE_W;

  // comparator modes
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_ONE = 3'h1;
  localparam logic [2:0] MODE_TWO = 3'h2;
  localparam logic [2:0] MODE_COMMON = 3'h3;
  localparam logic [2:0] MODE_COMMON_OUT = 3'h4;
  localparam logic [2:0] MODE_ONE_OUT = 3'h5;
  localparam logic [2:0] MODE_MUX_VREF = 3'h6;
  localparam logic [2:0] MODE_OFF = 3'h7;

  // analog pin masks over port A pins 0..5
  localparam logic [PA_W-1:0] MASK_ALL = 6'h0f;
  localparam logic [PA_W-1:0] MASK_ONE = 6'h09;
  localparam logic [PA_W-1:0] MASK_COMMON = 6'h0b;
  localparam logic [PA_W-1:0] MASK_NONE = 6'h00;

  localparam logic [PA_W-1:0] DIR_A_RESET = 6'h3f;
  localparam logic [PE_W-1:0] DIR_E_RESET = 3'h7;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic second_result_bit;
    logic first_result_bit;
    logic second_polarity_invert;
    logic first_polarity_invert;
    logic input_switch_bit;
    logic [2:0] comparator_mode_field;
  } dcc_ctrl_t;

  localparam dcc_ctrl_t CTRL_RESET = '{default: 1'b0};

  typedef struct packed {
    logic [1:0] cmp_power;
    logic vref_sel;
    logic input_switch;
    logic pin_out;
    logic [PA_W-1:0] analog_mask;
  } dcc_route_t;

  typedef struct packed {
    logic [1:0] cmp_power;
    logic vref_sel;
    logic input_switch;
    logic [2:0] mode;
  } dcc_ana_t;

endpackage : dcc_pkg

// ---- rtl/dcc_route.sv ----
// Purpose: decode of the comparator mode into power, routing and pin use
// Assumes: pure decode, registered by the caller
// Notes: port A pins 0..3 carry comparator inputs
`timescale 1ns/1ns
module dcc_route
  import dcc_pkg::*;
(
  input wire dcc_ctrl_t ctrl,
  output dcc_route_t route
);

  always_comb begin
    route = '0;
    route.input_switch = ctrl.input_switch_bit;
    case (ctrl.comparator_mode_field)
      // R20: reset mode
      MODE_RESET: begin
        route.analog_mask = MASK_ALL;
      end
      // R24: diagram pairings
      MODE_ONE: begin
        route.cmp_power = 2'h1;
        route.analog_mask = MASK_ONE;
      end
      MODE_TWO: begin
        route.cmp_power = 2'h3;
        route.analog_mask = MASK_ALL;
      end
      MODE_COMMON: begin
        route.cmp_power = 2'h3;
        route.analog_mask = MASK_COMMON;
      end
      MODE_COMMON_OUT: begin
        route.cmp_power = 2'h3;
        route.analog_mask = MASK_COMMON;
        route.pin_out = 1'b1;
      end
      MODE_ONE_OUT: begin
        route.cmp_power = 2'h1;
        route.analog_mask = MASK_ONE;
        route.pin_out = 1'b1;
      end
      // R4: reference only here
      MODE_MUX_VREF: begin
        route.cmp_power = 2'h3;
        route.vref_sel = 1'b1;
        route.analog_mask = MASK_ALL;
      end
      // R18: both comparators off
      MODE_OFF: begin
        route.analog_mask = MASK_NONE;
      end
      default: begin
        route.analog_mask = MASK_ALL;
      end
    endcase
  end

endmodule : dcc_route

// ---- rtl/dcc_sync.sv ----
// Purpose: three-flop input synchroniser with agreement filter
// Assumes: inputs are asynchronous to hclk
// Notes: the held value moves only when the second and third flops agree
`timescale 1ns/1ns
module dcc_sync
  import dcc_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync_out[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        sync_out[i] <= s3_q[i];
      end
    end
  end

endmodule : dcc_sync

// ---- rtl/dcc_top.sv ----
// Purpose: control and status logic around two analog comparators
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: comparator results and port pins are asynchronous inputs
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns

// Contract
// R1: three-bit mode field selects one of eight comparator configurations.
// R2: direction bits govern comparator pin direction in every mode.
// R3: raw result high when plus input exceeds minus input.
// R4: internal reference only in mode 110, on both plus inputs.
// R5: both result bits are read-only status in the control register.
// R6: port E pins 1 and 2 carry unsynchronised outputs when enabled.
// R7: port E direction bits still enable those pin drivers.
// R8: per-comparator invert bit flips status bits and pin outputs.
// R9: flag sets when an output differs from the last latched value.
// R10: flag clears only by writing zero; writing one sets it.
// R11: request only when flag enable, peripheral and global enables set.
// R12: any control access latches outputs; mismatch keeps setting the flag.
// R13: a change coinciding with a control read may not set the flag.
// R14: software ends the mismatch first, then clears the flag.
// R15: software disables the interrupt while changing the mode.
// R16: software waits the response delay after changing sources.
// R17: comparators keep running in sleep; enabled interrupt wakes the device.
// R18: mode 111 powers both comparators off.
// R19: waking from sleep leaves the control register untouched.
// R20: reset restores mode 000 with pins analog and comparators off.
// R21: port reads return zero on pins used as analog inputs.
// R22: in mode 110 the switch bit picks plus or minus pin routing.
// R23: set invert bit reads one when plus input is below minus.
// R24: modes 001 to 101 follow the fixed pairing table.
module dcc_top
  import dcc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] cmp_raw,
  input wire logic [PA_W-1:0] port_a_in,
  input wire logic [PE_W-1:0] port_e_in,
  input wire logic sleep_active,
  output dcc_ana_t ana_ctrl,
  output logic [PA_W-1:0] port_a_oe,
  output logic [PA_W-1:0] port_a_digital_en,
  output logic port_e_pin_one,
  output logic port_e_pin_one_oe,
  output logic port_e_pin_two,
  output logic port_e_pin_two_oe,
  output logic irq,
  output logic irq_priority,
  output logic wake
);

  dcc_ctrl_t ctrl_q;
  dcc_ctrl_t wr_ctrl;
  dcc_route_t route_d;
  dcc_route_t route_q;
  logic [PA_W-1:0] dir_a_q;
  logic [PE_W-1:0] dir_e_q;
  logic flag_q;
  logic flag_d;
  logic compare_change_irq_enable_q;
  logic prio_q;
  logic peripheral_irq_enable_q;
  logic gie_q;
  logic [1:0] latched_q;
  logic [1:0] cmp_out;
  logic [1:0] cmp_inv;
  logic mismatch;
  logic [SYNC_W-1:0] sync_v;
  logic [1:0] cmp_sync;
  logic [PA_W-1:0] pa_sync;
  logic [PE_W-1:0] pe_sync;
  logic addr_phase;
  logic dp_wr_q;
  logic [31:0] dp_addr_q;
  logic ctrl_access;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction : hit

  dcc_sync #(.W(SYNC_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({port_e_in, port_a_in, cmp_raw}),
    .sync_out(sync_v)
  );

  assign cmp_sync = sync_v[1:0];
  assign pa_sync = sync_v[2 +: PA_W];
  assign pe_sync = sync_v[2 + PA_W +: PE_W];

  dcc_route u_route (
    .ctrl(ctrl_q),
    .route(route_d)
  );

  // bus phases
  assign addr_phase = hsel && hready && htrans[1];
  assign ctrl_access = addr_phase && hit(haddr, OFF_CTRL);
  // write data seen through the control field layout
  assign wr_ctrl = dcc_ctrl_t'(hwdata[$bits(dcc_ctrl_t)-1:0]);

  // comparator outputs as software sees them
  assign cmp_inv = {ctrl_q.second_polarity_invert, ctrl_q.first_polarity_invert};
  // R3: result from the analog side
  // R8: inversion applied per comparator
  // R23: inverted polarity view
  assign cmp_out = (cmp_sync & route_q.cmp_power) ^ cmp_inv;
  // R9: change against latched value
  assign mismatch = (cmp_out != latched_q);

  function automatic logic [31:0] read_mux(input logic [31:0] a);
    logic [31:0] v;
    v = WORD_ZERO;
    if (hit(a, OFF_CTRL)) begin
      // R5: live results, never stored
      v[$bits(dcc_ctrl_t)-1:0] = {cmp_out[1], cmp_out[0], ctrl_q.second_polarity_invert,
                ctrl_q.first_polarity_invert, ctrl_q.input_switch_bit,
                ctrl_q.comparator_mode_field};
    end else if (hit(a, OFF_IRQ)) begin
      v[IRQ_FLAG_BIT] = flag_q;
      v[IRQ_EN_BIT] = compare_change_irq_enable_q;
      v[IRQ_PRIO_BIT] = prio_q;
    end else if (hit(a, OFF_CORE)) begin
      v[CORE_PERI_BIT] = peripheral_irq_enable_q;
      v[CORE_GLOB_BIT] = gie_q;
    end else if (hit(a, OFF_DIR_A)) begin
      v[PA_W-1:0] = dir_a_q;
    end else if (hit(a, OFF_DIR_E)) begin
      v[PE_W-1:0] = dir_e_q;
    end else if (hit(a, OFF_PORT)) begin
      // R21: analog pins read zero
      v[PORT_A_LSB +: PA_W] = pa_sync & ~route_q.analog_mask;
      v[PORT_E_LSB +: PE_W] = pe_sync;
    end
    read_mux = v;
  endfunction : read_mux

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= WORD_ZERO;
    end else begin
      dp_wr_q <= addr_phase && hwrite;
      dp_addr_q <= addr_phase ? haddr : WORD_ZERO;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= WORD_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (addr_phase && !hwrite) ? read_mux(haddr) : WORD_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // R1: mode, switch and invert bits writable
  // R19: only bus writes and reset change it
  // R20: reset selects mode 000
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (dp_wr_q && hit(dp_addr_q, OFF_CTRL)) begin
      ctrl_q.comparator_mode_field <= wr_ctrl.comparator_mode_field;
      ctrl_q.input_switch_bit <= wr_ctrl.input_switch_bit;
      ctrl_q.first_polarity_invert <= wr_ctrl.first_polarity_invert;
      ctrl_q.second_polarity_invert <= wr_ctrl.second_polarity_invert;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route_q <= '0;
    end else begin
      route_q <= route_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_a_q <= DIR_A_RESET;
      dir_e_q <= DIR_E_RESET;
      compare_change_irq_enable_q <= 1'b0;
      prio_q <= 1'b0;
      peripheral_irq_enable_q <= 1'b0;
      gie_q <= 1'b0;
    end else if (dp_wr_q) begin
      if (hit(dp_addr_q, OFF_DIR_A)) begin
        dir_a_q <= hwdata[PA_W-1:0];
      end
      if (hit(dp_addr_q, OFF_DIR_E)) begin
        dir_e_q <= hwdata[PE_W-1:0];
      end
      if (hit(dp_addr_q, OFF_IRQ)) begin
        compare_change_irq_enable_q <= hwdata[IRQ_EN_BIT];
        prio_q <= hwdata[IRQ_PRIO_BIT];
      end
      if (hit(dp_addr_q, OFF_CORE)) begin
        peripheral_irq_enable_q <= hwdata[CORE_PERI_BIT];
        gie_q <= hwdata[CORE_GLOB_BIT];
      end
    end
  end

  // R12: any control access latches
  // R13: change in the access cycle still sets the flag and is latched at the same edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latched_q <= 2'h0;
    end else if (ctrl_access) begin
      latched_q <= cmp_out;
    end
  end

  // R10: write zero clears, write one sets
  // R12: mismatch outranks the clear
  always_comb begin
    flag_d = flag_q;
    if (dp_wr_q && hit(dp_addr_q, OFF_IRQ)) begin
      flag_d = hwdata[IRQ_FLAG_BIT];
    end
    if (mismatch) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // R11: three enables gate the request
  // R17: wake needs only the local enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
      irq_priority <= 1'b0;
      wake <= 1'b0;
    end else begin
      irq <= flag_q && compare_change_irq_enable_q && peripheral_irq_enable_q && gie_q;
      irq_priority <= prio_q;
      wake <= sleep_active && flag_q && compare_change_irq_enable_q;
    end
  end

  // R4: reference select to analog side
  // R22: switch bit routes the inputs
  // R18: power follows the decoded mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ana_ctrl <= '0;
    end else begin
      ana_ctrl.cmp_power <= route_d.cmp_power;
      ana_ctrl.vref_sel <= route_d.vref_sel;
      ana_ctrl.input_switch <= route_d.vref_sel && route_d.input_switch;
      ana_ctrl.mode <= ctrl_q.comparator_mode_field;
    end
  end

  // R2: direction from the direction bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_oe <= '0;
      port_a_digital_en <= '0;
    end else begin
      port_a_oe <= ~dir_a_q;
      port_a_digital_en <= ~route_d.analog_mask;
    end
  end

  // R7: direction bits enable the drivers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_e_pin_one_oe <= 1'b0;
      port_e_pin_two_oe <= 1'b0;
    end else begin
      port_e_pin_one_oe <= route_q.pin_out && !dir_e_q[PIN_E_ONE];
      port_e_pin_two_oe <= route_q.pin_out && !dir_e_q[PIN_E_TWO];
    end
  end

  // R6: raw path, no register on purpose
  assign port_e_pin_one = (cmp_raw[0] & route_q.cmp_power[0]) ^ cmp_inv[0];
  assign port_e_pin_two = (cmp_raw[1] & route_q.cmp_power[1]) ^ cmp_inv[1];

  sequence s_ctrl_access;
    ctrl_access;
  endsequence

  sequence s_irq_clear;
    dp_wr_q && hit(dp_addr_q, OFF_IRQ) && !hwdata[IRQ_FLAG_BIT];
  endsequence

  a_flag_on_mismatch: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    mismatch |=> flag_q)
    else $error("flag not set on mismatch");

  a_flag_clear_write: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    s_irq_clear and !mismatch |=> !flag_q)
    else $error("flag not cleared by zero write");

  a_irq_three_enables: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    irq |-> $past(flag_q && compare_change_irq_enable_q && peripheral_irq_enable_q && gie_q))
    else $error("request without all enables");

  a_access_ends_mismatch: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    s_ctrl_access ##1 $stable(cmp_out) |-> !mismatch)
    else $error("mismatch survives control access");

  a_read_results: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    s_ctrl_access and !hwrite |=> hrdata[7:6] == $past(cmp_out))
    else $error("result bits differ from outputs");

  a_vref_mode_only: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    ana_ctrl.vref_sel |-> $past(ctrl_q.comparator_mode_field) == MODE_MUX_VREF)
    else $error("reference outside mux mode");

  a_off_mode_power: assert property (@(posedge hclk) disable iff (!hresetn) // R18
    ctrl_q.comparator_mode_field == MODE_OFF |=> ana_ctrl.cmp_power == 2'h0)
    else $error("comparators powered in off mode");

  a_wake_in_sleep: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    sleep_active && flag_q && compare_change_irq_enable_q |=> wake)
    else $error("no wake on enabled flag");

  a_pin_oe_dir: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    port_e_pin_one_oe |-> $past(route_q.pin_out) && !$past(dir_e_q[PIN_E_ONE]))
    else $error("pin driven without direction");

  a_analog_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R21
    addr_phase && !hwrite && hit(haddr, OFF_PORT)
      |=> (hrdata[PA_W-1:0] & $past(route_q.analog_mask)) == '0)
    else $error("analog pin read nonzero");

endmodule : dcc_top
